// [common/line_defines.svh]
// Purpose: Shared constants for the framer-side line port and its framer end
// Assumes: CLOCK at 20 MHz, link bit period of 400 ns
// Notes:   Included by bare name; definitions only
`ifndef LINE_DEFINES_SVH
`define LINE_DEFINES_SVH

`define CHANNELS            8
`define SYMBOL_WIDTH        16
`define FIFO_DEPTH          32

`define CLOCK_PERIOD_NS     50
`define LINK_PERIOD_NS      400
`define LINK_PERIOD_CYCLES  (`LINK_PERIOD_NS / `CLOCK_PERIOD_NS)
`define LINK_HALF_CYCLES    (`LINK_PERIOD_CYCLES / 2)
`define LINK_PHASE_WIDTH    3

`define UNIPOLAR_QUALIFY    16
`define QUALIFY_WIDTH       5

`define LANE_RESET          8'h00
`define LANE_ONES           8'hFF

`endif

// [common/line_pkg.sv]
// Purpose: Types and the shared line-code decoder step
// Assumes: Decoder advances once per bit period
// Notes:   Polarity bit 1 means a positive mark
package line_pkg;

  typedef enum logic [1:0] {SYM_SPACE, SYM_MARK, SYM_VIOL} symbol_type;

  typedef enum logic {MODE_BIPOLAR, MODE_UNIPOLAR} mode_type;

  typedef struct packed {
    logic [2:0] data_pipe;
    logic [2:0] flag_pipe;
    logic       last_pol;
    logic       seen;
    logic       data;
    logic       flag;
  } dec_state_type;

  typedef struct packed {
    symbol_type [3:0] pipe;
    logic             odd;
    logic             last_pol;
    logic             plus;
    logic             minus;
  } enc_state_type;

  // One bit of alternate-mark decoding, with optional zero-substitution removal
  function automatic dec_state_type decode_step(input dec_state_type s, input logic plus,
                                                input logic minus, input logic hdb3);
    dec_state_type n;
    logic          mark;
    logic          violation;
    logic          code;
    n = s;
    mark = plus | minus;
    violation = mark && s.seen && (plus == s.last_pol);
    code = hdb3 && violation && !s.data_pipe[0] && !s.data_pipe[1];
    n.data = s.data_pipe[2] & ~code;
    n.flag = s.flag_pipe[2];
    n.data_pipe = {s.data_pipe[1:0], mark & ~code};
    n.flag_pipe = {s.flag_pipe[1:0], violation & ~code};
    if (mark) begin
      n.last_pol = plus;
      n.seen = 1'b1;
    end
    return n;
  endfunction

endpackage

// [common/framer_link_if.sv]
// Purpose: Framer-side pins between the line port and the framer
// Assumes: All signals are plain logic levels
// Notes:   tx_minus_rail doubles as the per-channel unipolar select
`timescale 1ns/1ps
`default_nettype none
`include "line_defines.svh"

interface framer_link_if;
  logic                 rx_receive_clock;
  logic [`CHANNELS-1:0] rx_plus_rail;
  logic [`CHANNELS-1:0] rx_minus_rail;
  logic                 clock_edge_select;
  logic                 tx_input_clock;
  logic [`CHANNELS-1:0] tx_plus_rail;
  logic [`CHANNELS-1:0] tx_minus_rail;

  modport device (
    output rx_receive_clock,
    output rx_plus_rail,
    output rx_minus_rail,
    input  clock_edge_select,
    input  tx_input_clock,
    input  tx_plus_rail,
    input  tx_minus_rail
  );

  modport framer (
    input  rx_receive_clock,
    input  rx_plus_rail,
    input  rx_minus_rail,
    output clock_edge_select,
    output tx_input_clock,
    output tx_plus_rail,
    output tx_minus_rail
  );
endinterface

`default_nettype wire

// [rtl/line_fifo.sv]
// Purpose: Flop-based FIFO with valid and ready on both sides
// Assumes: Single clock
// Notes:   in_ready is registered
`timescale 1ns/1ps
`default_nettype none

module line_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire              push       = in_valid && in_ready;
  wire              pop        = out_valid && out_ready;
  wire [AW:0]       next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr   <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr   <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count    <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule // line_fifo

`default_nettype wire

// [rtl/line_port.sv]
// Purpose: Line transceiver end of the framer-side port, eight channels
// Assumes: Line symbols arrive through a FIFO in CLOCK's domain
// Notes:   Receive clock is divided from CLOCK; transmit clock is sampled
`timescale 1ns/1ps
`default_nettype none
`include "line_defines.svh"

module line_port (
  input  wire logic                 CLOCK,
  input  wire logic                 NRST,
  input  wire logic                 LINE_RX_VALID,
  output logic                      LINE_RX_READY,
  input  wire logic [`CHANNELS-1:0] LINE_RX_PLUS,
  input  wire logic [`CHANNELS-1:0] LINE_RX_MINUS,
  input  wire logic                 LINE_CODE_HDB3,
  output wire logic [`CHANNELS-1:0] LINE_TX_PLUS,
  output wire logic [`CHANNELS-1:0] LINE_TX_MINUS,
  output wire logic [`CHANNELS-1:0] UNIPOLAR_ACTIVE,
  framer_link_if.device             link
);

  // One bit of unipolar transmit encoding with optional zero substitution
  function automatic line_pkg::enc_state_type encode_step(input line_pkg::enc_state_type s,
                                                          input logic data, input logic hdb3);
    line_pkg::enc_state_type n;
    logic                    sub;
    n = s;
    sub = hdb3 && !data && (s.pipe[0] == line_pkg::SYM_SPACE)
          && (s.pipe[1] == line_pkg::SYM_SPACE) && (s.pipe[2] == line_pkg::SYM_SPACE);
    n.plus = 1'b0;
    n.minus = 1'b0;
    case (s.pipe[3])
      line_pkg::SYM_MARK: begin
        n.plus = ~s.last_pol;
        n.minus = s.last_pol;
        n.last_pol = ~s.last_pol;
      end
      line_pkg::SYM_VIOL: begin
        n.plus = s.last_pol;
        n.minus = ~s.last_pol;
      end
      default: begin
        n.plus = 1'b0;
      end
    endcase
    n.pipe[3] = (sub && !s.odd) ? line_pkg::SYM_MARK : s.pipe[2];
    n.pipe[2] = s.pipe[1];
    n.pipe[1] = s.pipe[0];
    n.pipe[0] = sub ? line_pkg::SYM_VIOL : (data ? line_pkg::SYM_MARK : line_pkg::SYM_SPACE);
    n.odd = sub ? 1'b0 : (s.odd ^ data);
    return n;
  endfunction

  // Link input synchronisers
  logic [`CHANNELS-1:0] tx_plus_meta;
  logic [`CHANNELS-1:0] tx_plus_sync;
  logic [`CHANNELS-1:0] tx_minus_meta;
  logic [`CHANNELS-1:0] tx_minus_sync;
  logic                 tx_clock_meta;
  logic                 tx_clock_sync;
  logic                 tx_clock_last;
  logic                 edge_meta;
  logic                 edge_sync;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      tx_plus_meta  <= `LANE_RESET;
      tx_plus_sync  <= `LANE_RESET;
      tx_minus_meta <= `LANE_RESET;
      tx_minus_sync <= `LANE_RESET;
      tx_clock_meta <= 1'b0;
      tx_clock_sync <= 1'b0;
      tx_clock_last <= 1'b0;
      edge_meta     <= 1'b0;
      edge_sync     <= 1'b0;
    end else begin
      tx_plus_meta  <= link.tx_plus_rail;
      tx_plus_sync  <= tx_plus_meta;
      tx_minus_meta <= link.tx_minus_rail;
      tx_minus_sync <= tx_minus_meta;
      tx_clock_meta <= link.tx_input_clock;
      tx_clock_sync <= tx_clock_meta;
      tx_clock_last <= tx_clock_sync;
      edge_meta     <= link.clock_edge_select;
      edge_sync     <= edge_meta;
    end
  end

  // Rising edge of the framer's transmit clock
  wire tx_take = tx_clock_sync & ~tx_clock_last;

  // Receive clock divider
  logic [`LINK_PHASE_WIDTH-1:0] phase;
  logic                         rx_clock;
  wire  [`LINK_PHASE_WIDTH-1:0] next_phase = (phase == `LINK_PHASE_WIDTH'(`LINK_PERIOD_CYCLES - 1))
                                             ? '0 : `LINK_PHASE_WIDTH'(phase + 1'b1);
  wire                          next_rx_clock = (next_phase >= `LINK_PHASE_WIDTH'(`LINK_HALF_CYCLES));
  wire                          rx_launch = edge_sync ? (next_phase == '0)
                                            : (next_phase == `LINK_PHASE_WIDTH'(`LINK_HALF_CYCLES));

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      phase    <= '0;
      rx_clock <= 1'b0;
    end else begin
      phase    <= next_phase;
      rx_clock <= next_rx_clock;
    end
  end

  assign link.rx_receive_clock = rx_clock;

  // Received line symbols wait here for their bit slot
  logic                     fifo_valid;
  logic [`SYMBOL_WIDTH-1:0] fifo_data;

  line_fifo #(
    .WIDTH (`SYMBOL_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) line_fifo_inst (
    .clock     (CLOCK),
    .nrst      (NRST),
    .in_valid  (LINE_RX_VALID),
    .in_ready  (LINE_RX_READY),
    .in_data   ({LINE_RX_MINUS, LINE_RX_PLUS}),
    .out_valid (fifo_valid),
    .out_ready (rx_launch),
    .out_data  (fifo_data)
  );

  // An empty buffer sends spaces
  wire [`CHANNELS-1:0] line_plus  = fifo_valid ? fifo_data[`CHANNELS-1:0] : `LANE_RESET;
  wire [`CHANNELS-1:0] line_minus = fifo_valid ? fifo_data[`SYMBOL_WIDTH-1:`CHANNELS] : `LANE_RESET;

  wire [`CHANNELS-1:0] rx_plus_all;
  wire [`CHANNELS-1:0] rx_minus_all;

  for (genvar c = 0; c < `CHANNELS; c++) begin : lane
    logic [`QUALIFY_WIDTH-1:0] qualify;
    line_pkg::mode_type        mode;
    line_pkg::dec_state_type   dec;
    line_pkg::dec_state_type   next_dec;
    line_pkg::enc_state_type   enc;
    line_pkg::enc_state_type   next_enc;
    logic                      rx_p;
    logic                      rx_m;
    logic                      tx_p;
    logic                      tx_m;
    wire                       unipolar = (mode == line_pkg::MODE_UNIPOLAR);

    assign next_dec = line_pkg::decode_step(dec, line_plus[c], line_minus[c], LINE_CODE_HDB3);
    assign next_enc = encode_step(enc, tx_plus_sync[c], LINE_CODE_HDB3);

    // Mode qualification from this channel's own select pin
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        qualify <= '0;
        mode    <= line_pkg::MODE_BIPOLAR;
      end else if (!tx_minus_sync[c]) begin
        qualify <= '0;
        mode    <= line_pkg::MODE_BIPOLAR;
      end else if (qualify != `QUALIFY_WIDTH'(`UNIPOLAR_QUALIFY)) begin
        qualify <= `QUALIFY_WIDTH'(qualify + 1'b1);
      end else begin
        mode <= line_pkg::MODE_UNIPOLAR;
      end
    end

    // Receive rails, launched on the edge opposite the valid edge
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        dec  <= '0;
        rx_p <= 1'b0;
        rx_m <= 1'b0;
      end else if (rx_launch) begin
        dec  <= next_dec;
        rx_p <= unipolar ? next_dec.data : line_plus[c];
        rx_m <= unipolar ? next_dec.flag : line_minus[c];
      end
    end

    // Transmit line, taken on the transmit clock's rising edge
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        enc  <= '0;
        tx_p <= 1'b0;
        tx_m <= 1'b0;
      end else if (tx_take) begin
        enc  <= next_enc;
        tx_p <= unipolar ? next_enc.plus : tx_plus_sync[c];
        tx_m <= unipolar ? next_enc.minus : tx_minus_sync[c];
      end
    end

    assign rx_plus_all[c]     = rx_p;
    assign rx_minus_all[c]    = rx_m;
    assign LINE_TX_PLUS[c]    = tx_p;
    assign LINE_TX_MINUS[c]   = tx_m;
    assign UNIPOLAR_ACTIVE[c] = unipolar;
  end

  assign link.rx_plus_rail  = rx_plus_all;
  assign link.rx_minus_rail = rx_minus_all;

endmodule // line_port

`default_nettype wire

// [rtl/framer_end.sv]
// Purpose: Framer end of the framer-side port, eight channels
// Assumes: Mode, edge select and line code are levels in CLOCK's domain
// Notes:   Makes the transmit clock by dividing CLOCK
`timescale 1ns/1ps
`default_nettype none
`include "line_defines.svh"

module framer_end (
  input  wire logic                 CLOCK,
  input  wire logic                 NRST,
  input  wire logic [`CHANNELS-1:0] UNIPOLAR,
  input  wire logic                 EDGE_SELECT,
  input  wire logic                 LINE_CODE_HDB3,
  input  wire logic                 TX_VALID,
  output logic                      TX_READY,
  input  wire logic [`CHANNELS-1:0] TX_PLUS,
  input  wire logic [`CHANNELS-1:0] TX_MINUS,
  output logic                      RX_VALID,
  output wire logic [`CHANNELS-1:0] RX_PLUS,
  output wire logic [`CHANNELS-1:0] RX_MINUS,
  framer_link_if.framer             link
);

  logic [`CHANNELS-1:0] rx_plus_meta;
  logic [`CHANNELS-1:0] rx_plus_sync;
  logic [`CHANNELS-1:0] rx_minus_meta;
  logic [`CHANNELS-1:0] rx_minus_sync;
  logic                 rx_clock_meta;
  logic                 rx_clock_sync;
  logic                 rx_clock_last;
  logic                 edge_drive;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rx_plus_meta  <= `LANE_RESET;
      rx_plus_sync  <= `LANE_RESET;
      rx_minus_meta <= `LANE_RESET;
      rx_minus_sync <= `LANE_RESET;
      rx_clock_meta <= 1'b0;
      rx_clock_sync <= 1'b0;
      rx_clock_last <= 1'b0;
      edge_drive    <= 1'b0;
    end else begin
      rx_plus_meta  <= link.rx_plus_rail;
      rx_plus_sync  <= rx_plus_meta;
      rx_minus_meta <= link.rx_minus_rail;
      rx_minus_sync <= rx_minus_meta;
      rx_clock_meta <= link.rx_receive_clock;
      rx_clock_sync <= rx_clock_meta;
      rx_clock_last <= rx_clock_sync;
      edge_drive    <= EDGE_SELECT;
    end
  end

  assign link.clock_edge_select = edge_drive;

  // Capture on the receive clock edge that the edge select names
  wire rx_rise = rx_clock_sync & ~rx_clock_last;
  wire rx_fall = ~rx_clock_sync & rx_clock_last;
  wire rx_take = edge_drive ? rx_rise : rx_fall;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      RX_VALID <= 1'b0;
    end else begin
      RX_VALID <= rx_take;
    end
  end

  for (genvar c = 0; c < `CHANNELS; c++) begin : lane
    line_pkg::dec_state_type dec;
    line_pkg::dec_state_type next_dec;
    logic                    data;
    logic                    flag;

    assign next_dec = line_pkg::decode_step(dec, rx_plus_sync[c], rx_minus_sync[c], LINE_CODE_HDB3);

    // Bipolar rails are decoded here; unipolar ones arrive decoded
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        dec  <= '0;
        data <= 1'b0;
        flag <= 1'b0;
      end else if (rx_take) begin
        dec  <= next_dec;
        data <= UNIPOLAR[c] ? rx_plus_sync[c] : next_dec.data;
        flag <= UNIPOLAR[c] ? rx_minus_sync[c] : next_dec.flag;
      end
    end

    assign RX_PLUS[c]  = data;
    assign RX_MINUS[c] = flag;
  end

  // Transmit clock divider; rails change on its falling edge, except a minus rail forced high at once when its UNIPOLAR bit rises
  logic [`LINK_PHASE_WIDTH-1:0] phase;
  logic                         tx_clock;
  logic [`CHANNELS-1:0]         tx_plus;
  logic [`CHANNELS-1:0]         tx_minus;
  wire  [`LINK_PHASE_WIDTH-1:0] last_phase = `LINK_PHASE_WIDTH'(`LINK_PERIOD_CYCLES - 1);
  wire  [`LINK_PHASE_WIDTH-1:0] next_phase = (phase == last_phase) ? '0 : `LINK_PHASE_WIDTH'(phase + 1'b1);
  wire                          tx_step = TX_READY;
  wire  [`CHANNELS-1:0]         word_plus = TX_VALID ? TX_PLUS : `LANE_RESET;
  wire  [`CHANNELS-1:0]         word_minus = TX_VALID ? TX_MINUS : `LANE_RESET;
  wire  [`CHANNELS-1:0]         held_minus = tx_step ? word_minus : tx_minus;
  wire  [`CHANNELS-1:0]         next_minus = (held_minus & ~UNIPOLAR) | UNIPOLAR;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      phase    <= '0;
      tx_clock <= 1'b0;
      TX_READY <= 1'b0;
      tx_plus  <= `LANE_RESET;
      tx_minus <= `LANE_RESET;
    end else begin
      phase    <= next_phase;
      tx_clock <= (next_phase >= `LINK_PHASE_WIDTH'(`LINK_HALF_CYCLES));
      TX_READY <= (next_phase == last_phase);
      tx_plus  <= tx_step ? word_plus : tx_plus;
      tx_minus <= next_minus;
    end
  end

  assign link.tx_input_clock = tx_clock;
  assign link.tx_plus_rail   = tx_plus;
  assign link.tx_minus_rail  = tx_minus;

endmodule // framer_end

`default_nettype wire

// [bench/framer_link_asserts.sv]
// Purpose: Checks on the framer link wires between the two ends
// Assumes: One CLOCK domain, NRST asynchronous and active low
// Notes:   Instantiated beside the link interface
`timescale 1ns/1ps
`default_nettype none
`include "line_defines.svh"

module framer_link_asserts (
  input wire logic                 CLOCK,
  input wire logic                 NRST,
  input wire logic                 rx_receive_clock,
  input wire logic [`CHANNELS-1:0] rx_plus_rail,
  input wire logic [`CHANNELS-1:0] rx_minus_rail,
  input wire logic                 clock_edge_select,
  input wire logic                 tx_input_clock,
  input wire logic [`CHANNELS-1:0] tx_plus_rail,
  input wire logic [`CHANNELS-1:0] tx_minus_rail
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  wire logic [2*`CHANNELS-1:0] rails = {rx_minus_rail, rx_plus_rail};

  a_rx_clock_high: assert property ($rose(rx_receive_clock) |-> rx_receive_clock [*4] ##1 !rx_receive_clock)
    else $error("receive clock high phase not 4 cycles");
  a_rx_clock_low: assert property ($fell(rx_receive_clock) |-> !rx_receive_clock [*4] ##1 rx_receive_clock)
    else $error("receive clock low phase not 4 cycles");
  a_rail_launch_edge: assert property (!$stable(rails) |->
    (clock_edge_select ? $fell(rx_receive_clock) : $rose(rx_receive_clock)))
    else $error("receive rails changed off the launch edge");
  a_rail_bit_hold: assert property (!$stable(rails) |=> $stable(rails) [*7])
    else $error("receive rails did not hold a bit period");
  a_tx_clock_high: assert property ($rose(tx_input_clock) |-> tx_input_clock [*4] ##1 !tx_input_clock)
    else $error("transmit clock high phase not 4 cycles");
  a_tx_clock_low: assert property ($fell(tx_input_clock) |-> !tx_input_clock [*4] ##1 tx_input_clock)
    else $error("transmit clock low phase not 4 cycles");
  a_tx_data_launch: assert property (!$stable(tx_plus_rail) |-> $fell(tx_input_clock))
    else $error("transmit data changed off the falling clock");
  a_tx_hold_high: assert property (tx_input_clock |-> $stable(tx_plus_rail))
    else $error("transmit data moved while clock high");

  c_minus_mark: cover property (rx_receive_clock && rx_minus_rail != 8'h00);
  c_rise_launch: cover property (!clock_edge_select && $rose(rx_receive_clock) && !$stable(rails));
  c_tx_data: cover property ($fell(tx_input_clock) && tx_plus_rail != 8'h00);
endmodule // framer_link_asserts

`default_nettype wire

// [bench/framer_side_bipolar_unipolar_port_tb_top.sv]
// Purpose: Self-checking bench for both ends of the framer-side port
// Assumes: CLOCK 50 ns, link bit of 8 cycles
// Notes:   Queues collect link and line samples for later comparison
`timescale 1ns/1ps
`default_nettype none
`include "line_defines.svh"

module framer_side_bipolar_unipolar_port_tb_top;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        rx_valid = 1'b0;
  logic [15:0] rx_word = 16'h0000;
  logic        hdb3 = 1'b0;
  logic [7:0]  unipolar = 8'h00;
  logic        esel = 1'b1;
  logic        tx_valid = 1'b0;
  logic [7:0]  tx_plus = 8'h00;
  logic [7:0]  tx_minus = 8'h00;
  logic [7:0]  act_or = 8'h00;
  logic [15:0] idle_or = 16'h0000;
  logic        ptx = 1'b0;
  logic        prx = 1'b0;
  int          tdly = 0;
  int          cycles = 0;
  int          err_total = 0;
  int          check_count = 0;
  logic [15:0] txq[$];
  logic [15:0] rxq[$];
  logic [15:0] fq[$];
  wire logic       rx_ready, tx_ready, f_valid;
  wire logic [7:0] ltx_p, ltx_m, active, f_plus, f_minus;
  localparam logic [15:0] PA[8] = '{16'h00FF, 16'hFF00, 16'h0000, 16'hFF00, 16'h00FF, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] PB[8] = '{16'hFF00, 16'h00FF, 16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0000, 16'h0000};

  framer_link_if link ();
  line_port line_port_inst (.CLOCK(clock), .NRST(nrst), .LINE_RX_VALID(rx_valid), .LINE_RX_READY(rx_ready),
    .LINE_RX_PLUS(rx_word[7:0]), .LINE_RX_MINUS(rx_word[15:8]), .LINE_CODE_HDB3(hdb3),
    .LINE_TX_PLUS(ltx_p), .LINE_TX_MINUS(ltx_m), .UNIPOLAR_ACTIVE(active), .link(link));
  framer_end framer_end_inst (.CLOCK(clock), .NRST(nrst), .UNIPOLAR(unipolar), .EDGE_SELECT(esel),
    .LINE_CODE_HDB3(hdb3), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_PLUS(tx_plus), .TX_MINUS(tx_minus),
    .RX_VALID(f_valid), .RX_PLUS(f_plus), .RX_MINUS(f_minus), .link(link));
  framer_link_asserts framer_link_asserts_inst (.CLOCK(clock), .NRST(nrst),
    .rx_receive_clock(link.rx_receive_clock), .rx_plus_rail(link.rx_plus_rail),
    .rx_minus_rail(link.rx_minus_rail), .clock_edge_select(link.clock_edge_select),
    .tx_input_clock(link.tx_input_clock), .tx_plus_rail(link.tx_plus_rail), .tx_minus_rail(link.tx_minus_rail));

  always #(`CLOCK_PERIOD_NS / 2) clock = ~clock;

  // Collectors: line transmit bits, link rails at the valid edge, framer output
  always @(posedge clock) begin
    cycles <= cycles + 1;
    ptx <= link.tx_input_clock;
    prx <= link.rx_receive_clock;
    if (link.tx_input_clock && !ptx) tdly <= 6;
    else if (tdly > 0) tdly <= tdly - 1;
    if (tdly == 1) txq.push_back({ltx_m, ltx_p});
    if (link.rx_receive_clock != prx && link.rx_receive_clock == esel) rxq.push_back(
      {link.rx_minus_rail, link.rx_plus_rail});
    if (f_valid === 1'b1) fq.push_back({f_minus, f_plus});
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      act_or |= active;
    end
  endtask

  task automatic send_tx(input logic [7:0] p, input logic [7:0] m);
    int i;
    tx_valid <= 1'b1;
    tx_plus <= p;
    tx_minus <= m;
    i = 0;
    do begin
      step(1);
      i++;
    end while (tx_ready !== 1'b1 && i < 20);
  endtask

  task automatic tx_idle();
    tx_valid <= 1'b0;
    tx_plus <= 8'h00;
    tx_minus <= 8'h00;
  endtask

  task automatic push_rx(input logic [15:0] w, output int waits);
    rx_valid <= 1'b1;
    rx_word <= w;
    waits = 0;
    do begin
      @(posedge clock);
      waits++;
    end while (rx_ready !== 1'b1 && waits < 400);
  endtask

  task automatic t_mode();
    int i;
    check({8'h00, active}, 16'h0000, "reset mode");
    unipolar <= 8'h01;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (link.tx_minus_rail[0] !== 1'b1 && i < 20);
    step(18);
    check({8'h00, active}, 16'h0000, "select high 16 samples");
    step(4);
    check({8'h00, active}, 16'h0001, "select high 17 samples");
    unipolar <= 8'h00;
    step(16);
    check({8'h00, active}, 16'h0000, "select low");
    act_or = 8'h00;
    send_tx(8'h00, 8'h04);
    send_tx(8'h00, 8'h04);
    send_tx(8'h00, 8'h00);
    send_tx(8'h00, 8'h04);
    send_tx(8'h00, 8'h04);
    send_tx(8'h00, 8'h00);
    tx_idle();
    step(40);
    check({8'h00, act_or}, 16'h0000, "two minus bits stay bipolar");
  endtask

  task automatic t_btx();
    logic [15:0] w[4] = '{16'h245A, 16'h4281, 16'h1800, 16'h8124};
    int          r[$];
    int          k;
    txq.delete();
    foreach (w[j]) send_tx(w[j][7:0], w[j][15:8]);
    tx_idle();
    step(48);
    r = txq.find_first_index(item) with (item === w[0]);
    k = (r.size() > 0) ? r[0] : 0;
    foreach (w[j]) check(txq[k+j], w[j], "bipolar transmit");
  endtask

  task automatic t_rx(input logic e, input logic h, input logic u, input logic [15:0] s[8],
                      input logic [7:0] d, input logic [7:0] f);
    int r[$];
    int k;
    int n;
    esel <= e;
    hdb3 <= h;
    step(40);
    rxq.delete();
    fq.delete();
    foreach (s[j]) push_rx(s[j], n);
    rx_valid <= 1'b0;
    step(200);
    r = rxq.find_first_index(item) with (item[7:0] !== 8'h00);
    k = (r.size() > 0) ? r[0] : 0;
    for (int j = 1; j < 8; j++) check(rxq[k+j], u ? {{8{f[j]}}, {8{d[j]}}} : s[j], "link rails");
    r = fq.find_first_index(item) with (item[7:0] !== 8'h00);
    k = (r.size() > 0) ? r[0] : 0;
    for (int j = 1; j < 8; j++) check(fq[k+j], {{8{f[j]}}, {8{d[j]}}}, "framer data");
  endtask

  task automatic t_fifo();
    int n;
    int w;
    n = 0;
    do begin
      push_rx(16'h0000, w);
      n++;
    end while (w == 1 && n < 50);
    rx_valid <= 1'b0;
    check({15'h0000, n >= 33 && n <= 40}, 16'h0001, "buffer refusal point");
    step(300);
    check({15'h0000, rx_ready}, 16'h0001, "buffer drained");
  endtask

  task automatic t_utx();
    logic [7:0]  d[6] = '{8'hFF, 8'h0F, 8'hFF, 8'hF0, 8'h00, 8'hFF};
    logic [7:0]  pol;
    logic [7:0]  seen;
    logic [15:0] m;
    int          r[$];
    int          k;
    step(64);
    txq.delete();
    foreach (d[j]) send_tx(d[j], 8'h00);
    tx_idle();
    step(80);
    r = txq.find_first_index(item) with (item !== 16'h0000);
    k = (r.size() > 0) ? r[0] : 0;
    pol = 8'h00;
    seen = 8'h00;
    foreach (d[j]) begin
      m = txq[k+j];
      check({m[7:0] & m[15:8], m[7:0] | m[15:8]}, {8'h00, d[j]}, "unipolar marks");
      check({8'h00, m[7:0] & seen & d[j]}, {8'h00, ~pol & seen & d[j]}, "mark alternation");
      pol = (pol & ~d[j]) | (m[7:0] & d[j]);
      seen |= d[j];
    end
  endtask

  initial begin
    step(6);
    nrst <= 1'b1;
    step(2);
    t_mode();
    $display("done: mode select");
    t_btx();
    $display("done: bipolar transmit");
    t_rx(1'b1, 1'b0, 1'b0, PA, 8'h1B, 8'h08);
    $display("done: bipolar receive");
    t_fifo();
    $display("done: buffer");
    unipolar <= 8'hFF;
    step(60);
    check({8'h00, active}, 16'h00FF, "all unipolar");
    t_utx();
    $display("done: unipolar transmit");
    t_rx(1'b0, 1'b0, 1'b1, PA, 8'h1B, 8'h08);
    $display("done: unipolar receive");
    t_rx(1'b1, 1'b1, 1'b1, PB, 8'h03, 8'h00);
    // Idle unipolar transmit under substitution code sends marks of both polarities
    for (int j = 1; j <= 8; j++) idle_or |= txq[txq.size() - j];
    check(idle_or, 16'hFFFF, "substituted idle marks");
    $display("done: substitution decode");
    report_and_stop();
  end
endmodule // framer_side_bipolar_unipolar_port_tb_top

`default_nettype wire
